// >>> rtl/wcr_pkg.sv
// wake clock-recovery configuration: shared constants and carrier types
// assumes an 8-bit register space reached by decoded serial commands
package wcr_pkg;

  // ----------------------------------------------------------------
  // register addresses (7-bit command address)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_OSC_CAL_LOW  = 7'h3B;
  localparam logic [6:0] ADDR_CTRL_A       = 7'h3C;
  localparam logic [6:0] ADDR_CLK_SELECT   = 7'h3D;
  localparam logic [6:0] ADDR_UPPER_LIMIT  = 7'h3E;
  localparam logic [6:0] ADDR_LOWER_LIMIT  = 7'h3F;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          BIT_RECOVERY_ON  = 0;
  localparam int          FILT_LSB         = 2;
  localparam int          FILT_MSB         = 3;
  localparam int          CLKSEL_LSB       = 0;
  localparam int          CLKSEL_MSB       = 1;
  localparam logic [7:0]  RST_OSC_CAL_LOW  = 8'h00;
  localparam logic [7:0]  RST_CTRL_A       = 8'h04;
  localparam logic [7:0]  RST_CLK_SELECT   = 8'h00;
  localparam logic [7:0]  RST_UPPER_LIMIT  = 8'hA8;
  localparam logic [7:0]  RST_LOWER_LIMIT  = 8'h98;
  localparam logic [7:0]  RST_MEASURED     = 8'hA0;
  localparam logic [7:0]  READ_ZERO        = 8'h00;

  // ----------------------------------------------------------------
  // loop filter codes and their shift (log2 of time constant)
  // ----------------------------------------------------------------
  localparam logic [1:0]  FILT_TC8         = 2'h0;
  localparam logic [1:0]  FILT_TC16        = 2'h1;
  localparam logic [1:0]  FILT_TC32        = 2'h2;
  localparam logic [1:0]  FILT_ADAPT       = 2'h3;
  localparam logic [2:0]  SHIFT_TC8        = 3'h3;
  localparam logic [2:0]  SHIFT_TC16       = 3'h4;
  localparam logic [2:0]  SHIFT_TC32       = 3'h5;
  localparam logic [3:0]  ADAPT_SLOW_MAX   = 4'h3;
  localparam logic [3:0]  ADAPT_MID_MAX    = 4'h8;

  // ----------------------------------------------------------------
  // recovery clock selects, as ticks per 40 MHz system cycle
  // ----------------------------------------------------------------
  localparam logic [1:0]  CLK_80MHZ        = 2'h0;
  localparam logic [1:0]  CLK_40MHZ        = 2'h1;
  localparam logic [1:0]  CLK_20MHZ        = 2'h2;
  localparam logic [1:0]  CLK_10MHZ        = 2'h3;
  localparam logic [1:0]  INC_DOUBLE       = 2'h2;
  localparam logic [1:0]  INC_SINGLE       = 2'h1;
  localparam logic [1:0]  INC_NONE         = 2'h0;
  localparam logic [1:0]  DIV20_MASK       = 2'h1;
  localparam logic [1:0]  DIV10_MASK       = 2'h3;

  // ----------------------------------------------------------------
  // measurement arithmetic
  // ----------------------------------------------------------------
  localparam int          FRAC_BITS        = 4;
  localparam int          FX_W             = 12;
  localparam int          CNT_W            = 12;
  localparam logic [3:0]  MAX_EDGE_BITS    = 4'hA;
  localparam logic [CNT_W-1:0] CNT_MAX     = 12'hFFF;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [6:0] addr;
    logic [7:0] wdata;
  } wcr_cmd_t;

  typedef struct packed {
    logic       recovery_on;
    logic [1:0] loop_filter_constant;
    logic [1:0] clk_select;
  } wcr_ctrl_t;

endpackage

// >>> rtl/wcr_tick_gen.sv
// recovery-clock tick generator: how many recovery clock periods elapse per system cycle
// assumes a 40 MHz system clock; 80 MHz is modelled as two ticks per cycle
`timescale 1ns/10ps
`default_nettype none
module wcr_tick_gen (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       clear_in,
  input  wire logic [1:0] clk_select_in,
  output var  logic [1:0] tick_inc_out
);

  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic [1:0] inc_reg;
  logic [1:0] inc_next;

  always_comb begin
    div_next = div_reg + 2'h1;
    inc_next = wcr_pkg::INC_NONE;
    unique case (clk_select_in)
      wcr_pkg::CLK_80MHZ: inc_next = wcr_pkg::INC_DOUBLE;
      wcr_pkg::CLK_40MHZ: inc_next = wcr_pkg::INC_SINGLE;
      wcr_pkg::CLK_20MHZ: inc_next = ((div_reg & wcr_pkg::DIV20_MASK) == 2'h0) ? wcr_pkg::INC_SINGLE
                                                                                : wcr_pkg::INC_NONE;
      wcr_pkg::CLK_10MHZ: inc_next = ((div_reg & wcr_pkg::DIV10_MASK) == 2'h0) ? wcr_pkg::INC_SINGLE
                                                                                : wcr_pkg::INC_NONE;
    endcase
    if (clear_in) begin
      div_next = 2'h0;
      inc_next = wcr_pkg::INC_NONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div_reg <= 2'h0;
      inc_reg <= wcr_pkg::INC_NONE;
    end else begin
      div_reg <= div_next;
      inc_reg <= inc_next;
    end
  end

  assign tick_inc_out = inc_reg;

endmodule
`default_nettype wire

// >>> rtl/wcr_config_regs.sv
// wake clock-recovery configuration registers and bit-time measurement loop
// assumes commands arrive already decoded from the serial frame, one per cycle at most,
// and that rx_in is synchronous to clk_in
//
// Function
// - recovery runs only while recovery_on is set
// - filter codes 00/01/10 give 8/16/32
// - code 11 adapts constant to falling-edge spacing
// - reserved bits read zero, writes ignored
// - clock select picks 80/40/20/10 MHz recovery rate
// - measured bit time clamped to upper bound
// - measured bit time clamped to lower bound
// - control reset 0x04; restart keeps filter, enable
// - limits reset A8/98; restart keeps them
// - read-only calibration byte, zero at reset
`timescale 1ns/10ps
`default_nettype none
module wcr_config_regs (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              soft_reset_in,
  input  wire logic              restart_in,
  input  wire wcr_pkg::wcr_cmd_t cmd_in,
  input  wire logic              cal_load_in,
  input  wire logic [7:0]        cal_value_in,
  input  wire logic              rx_in,
  output var  logic [7:0]        rdata_out,
  output var  logic              rdata_valid_out,
  output var  wcr_pkg::wcr_ctrl_t ctrl_out,
  output var  logic [7:0]        measured_bit_length_out,
  output var  logic              measure_update_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] filt_shift(input logic [1:0] code, input logic [3:0] nbits);
    logic [2:0] s;
    s = wcr_pkg::SHIFT_TC16;
    unique case (code)
      wcr_pkg::FILT_TC8:   s = wcr_pkg::SHIFT_TC8;
      wcr_pkg::FILT_TC16:  s = wcr_pkg::SHIFT_TC16;
      wcr_pkg::FILT_TC32:  s = wcr_pkg::SHIFT_TC32;
      wcr_pkg::FILT_ADAPT: begin
        if (nbits <= wcr_pkg::ADAPT_SLOW_MAX)
          s = wcr_pkg::SHIFT_TC32;
        else if (nbits <= wcr_pkg::ADAPT_MID_MAX)
          s = wcr_pkg::SHIFT_TC16;
        else
          s = wcr_pkg::SHIFT_TC8;
      end
    endcase
    return s;
  endfunction

  function automatic logic [wcr_pkg::FX_W-1:0] to_fx(input logic [7:0] v);
    return {v, {wcr_pkg::FRAC_BITS{1'b0}}};
  endfunction

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic       recovery_on_reg,  recovery_on_next;
  logic [1:0] filt_reg,         filt_next;
  logic [1:0] clk_sel_reg,      clk_sel_next;
  logic [7:0] upper_reg,        upper_next;
  logic [7:0] lower_reg,        lower_next;
  logic [7:0] cal_low_reg,      cal_low_next;
  logic [7:0] rdata_reg,        rdata_next;
  logic       rvalid_reg,       rvalid_next;
  logic [7:0] read_mux;
  logic       por_or_soft;
  logic       do_write;

  assign por_or_soft = !rst_n_in || soft_reset_in;
  assign do_write    = cmd_in.valid && cmd_in.write;

  always_comb begin
    read_mux = wcr_pkg::READ_ZERO;
    unique case (cmd_in.addr)
      wcr_pkg::ADDR_OSC_CAL_LOW: read_mux = cal_low_reg;
      wcr_pkg::ADDR_CTRL_A: begin
        read_mux[wcr_pkg::BIT_RECOVERY_ON]            = recovery_on_reg;
        read_mux[wcr_pkg::FILT_MSB:wcr_pkg::FILT_LSB] = filt_reg;
      end
      wcr_pkg::ADDR_CLK_SELECT:  read_mux[wcr_pkg::CLKSEL_MSB:wcr_pkg::CLKSEL_LSB] = clk_sel_reg;
      wcr_pkg::ADDR_UPPER_LIMIT: read_mux = upper_reg;
      wcr_pkg::ADDR_LOWER_LIMIT: read_mux = lower_reg;
      default:                   read_mux = wcr_pkg::READ_ZERO;
    endcase
  end

  always_comb begin
    recovery_on_next = recovery_on_reg;
    filt_next        = filt_reg;
    clk_sel_next     = clk_sel_reg;
    upper_next       = upper_reg;
    lower_next       = lower_reg;
    cal_low_next     = cal_low_reg;
    rdata_next       = rdata_reg;
    rvalid_next      = cmd_in.valid;
    // the answer shows the contents before this command's write
    if (cmd_in.valid)
      rdata_next = read_mux;
    if (do_write) begin
      // only defined fields are stored; reserved positions are dropped
      unique case (cmd_in.addr)
        wcr_pkg::ADDR_CTRL_A: begin
          recovery_on_next = cmd_in.wdata[wcr_pkg::BIT_RECOVERY_ON];
          filt_next        = cmd_in.wdata[wcr_pkg::FILT_MSB:wcr_pkg::FILT_LSB];
        end
        wcr_pkg::ADDR_CLK_SELECT:  clk_sel_next = cmd_in.wdata[wcr_pkg::CLKSEL_MSB:wcr_pkg::CLKSEL_LSB];
        wcr_pkg::ADDR_UPPER_LIMIT: upper_next   = cmd_in.wdata;
        wcr_pkg::ADDR_LOWER_LIMIT: lower_next   = cmd_in.wdata;
        default: ;
      endcase
    end
    if (cal_load_in)
      cal_low_next = cal_value_in;
  end

  // restart deliberately touches none of these registers
  always_ff @(posedge clk_in) begin
    if (por_or_soft) begin
      recovery_on_reg <= wcr_pkg::RST_CTRL_A[wcr_pkg::BIT_RECOVERY_ON];
      filt_reg        <= wcr_pkg::RST_CTRL_A[wcr_pkg::FILT_MSB:wcr_pkg::FILT_LSB];
      clk_sel_reg     <= wcr_pkg::RST_CLK_SELECT[wcr_pkg::CLKSEL_MSB:wcr_pkg::CLKSEL_LSB];
      upper_reg       <= wcr_pkg::RST_UPPER_LIMIT;
      lower_reg       <= wcr_pkg::RST_LOWER_LIMIT;
      cal_low_reg     <= wcr_pkg::RST_OSC_CAL_LOW;
      rdata_reg       <= wcr_pkg::READ_ZERO;
      rvalid_reg      <= 1'b0;
    end else begin
      recovery_on_reg <= recovery_on_next;
      filt_reg        <= filt_next;
      clk_sel_reg     <= clk_sel_next;
      upper_reg       <= upper_next;
      lower_reg       <= lower_next;
      cal_low_reg     <= cal_low_next;
      rdata_reg       <= rdata_next;
      rvalid_reg      <= rvalid_next;
    end
  end

  // ----------------------------------------------------------------
  // recovery tick rate
  // ----------------------------------------------------------------
  logic [1:0] tick_inc;
  logic       engine_clear;

  // a disabled or restarting loop forgets its partial interval
  assign engine_clear = !recovery_on_reg || restart_in;

  wcr_tick_gen u_tick (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .clear_in      (engine_clear),
    .clk_select_in (clk_sel_reg),
    .tick_inc_out  (tick_inc)
  );

  // ----------------------------------------------------------------
  // bit-time measurement loop
  // ----------------------------------------------------------------
  logic                      rx_prev_reg,  rx_prev_next;
  logic                      armed_reg,    armed_next;
  logic [wcr_pkg::CNT_W-1:0] cnt_reg,      cnt_next;
  logic [wcr_pkg::FX_W-1:0]  bt_fx_reg,    bt_fx_next;
  logic                      upd_reg,      upd_next;
  logic                      fall;
  logic [3:0]                nbits;
  logic signed [17:0]        err;
  logic signed [17:0]        step;
  logic signed [17:0]        cand;
  logic signed [17:0]        best_abs;
  logic signed [17:0]        trial;
  logic signed [17:0]        bt_new;
  logic signed [17:0]        hi_fx;
  logic signed [17:0]        lo_fx;

  assign fall  = rx_prev_reg && !rx_in;
  assign hi_fx = 18'(to_fx(upper_reg));
  assign lo_fx = 18'(to_fx(lower_reg));

  // nearest whole number of bits for the interval just closed
  always_comb begin
    nbits    = 4'h0;
    err      = 18'sh0;
    best_abs = 18'sh1FFFF;
    cand     = 18'sh0;
    trial    = 18'sh0;
    for (int n = 1; n <= int'(wcr_pkg::MAX_EDGE_BITS); n++) begin
      trial = 18'(signed'({1'b0, cnt_reg, {wcr_pkg::FRAC_BITS{1'b0}}}) - n * signed'({6'h0, bt_fx_reg}));
      cand  = (trial < 0) ? -trial : trial;
      if (cand < best_abs) begin
        best_abs = cand;
        nbits    = 4'(n);
        err      = trial;
      end
    end
  end

  always_comb begin
    rx_prev_next = rx_in;
    armed_next   = armed_reg;
    cnt_next     = cnt_reg;
    bt_fx_next   = bt_fx_reg;
    upd_next     = 1'b0;
    step         = 18'sh0;
    bt_new       = 18'sh0;
    if (engine_clear) begin
      armed_next = 1'b0;
      cnt_next   = '0;
    end else if (fall) begin
      if (armed_reg && (cnt_reg != wcr_pkg::CNT_MAX)) begin
        step   = (err / 18'(signed'({1'b0, nbits}))) >>> filt_shift(filt_reg, nbits);
        bt_new = 18'(signed'({6'h0, bt_fx_reg}) + step);
        if (bt_new > hi_fx)
          bt_new = hi_fx;
        if (bt_new < lo_fx)
          bt_new = lo_fx;
        bt_fx_next = bt_new[wcr_pkg::FX_W-1:0];
        upd_next   = 1'b1;
      end
      armed_next = 1'b1;
      cnt_next   = '0;
    end else if (armed_reg) begin
      // saturate so an overlong gap is simply not used
      if (cnt_reg > wcr_pkg::CNT_MAX - 12'(tick_inc))
        cnt_next = wcr_pkg::CNT_MAX;
      else
        cnt_next = cnt_reg + 12'(tick_inc);
    end
  end

  always_ff @(posedge clk_in) begin
    if (por_or_soft) begin
      rx_prev_reg <= 1'b1;
      armed_reg   <= 1'b0;
      cnt_reg     <= '0;
      bt_fx_reg   <= to_fx(wcr_pkg::RST_MEASURED);
      upd_reg     <= 1'b0;
    end else begin
      rx_prev_reg <= rx_prev_next;
      armed_reg   <= armed_next;
      cnt_reg     <= cnt_next;
      bt_fx_reg   <= bt_fx_next;
      upd_reg     <= upd_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_out                        = rdata_reg;
  assign rdata_valid_out                  = rvalid_reg;
  assign ctrl_out.recovery_on             = recovery_on_reg;
  assign ctrl_out.loop_filter_constant    = filt_reg;
  assign ctrl_out.clk_select              = clk_sel_reg;
  assign measured_bit_length_out          = bt_fx_reg[wcr_pkg::FX_W-1:wcr_pkg::FRAC_BITS];
  assign measure_update_out               = upd_reg;

endmodule
`default_nettype wire

// >>> dv/wcr_config_regs_sva.sv
// checker for the wake recovery register bank, bound to its ports
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module wcr_config_regs_sva (
  input wire logic                clk_in,
  input wire logic                rst_n_in,
  input wire logic                soft_reset_in,
  input wire logic                restart_in,
  input wire wcr_pkg::wcr_cmd_t   cmd_in,
  input wire logic                cal_load_in,
  input wire logic [7:0]          cal_value_in,
  input wire logic                rx_in,
  input wire logic [7:0]          rdata_out,
  input wire logic                rdata_valid_out,
  input wire wcr_pkg::wcr_ctrl_t  ctrl_out,
  input wire logic [7:0]          measured_bit_length_out,
  input wire logic                measure_update_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----
  // shadow of the clamp limits, seen only through commands
  // ----
  logic       wr_ok;
  logic [7:0] upper_reg;
  logic [7:0] upper_next;
  logic [7:0] lower_reg;
  logic [7:0] lower_next;
  assign wr_ok = cmd_in.valid && cmd_in.write && !soft_reset_in;
  always_comb begin
    upper_next = upper_reg;
    lower_next = lower_reg;
    if (!rst_n_in || soft_reset_in) begin
      upper_next = 8'hA8;
      lower_next = 8'h98;
    end else if (wr_ok && cmd_in.addr == wcr_pkg::ADDR_UPPER_LIMIT) begin
      upper_next = cmd_in.wdata;
    end else if (wr_ok && cmd_in.addr == wcr_pkg::ADDR_LOWER_LIMIT) begin
      lower_next = cmd_in.wdata;
    end
  end
  always_ff @(posedge clk_in) begin
    upper_reg <= upper_next;
    lower_reg <= lower_next;
  end
  // ----
  // properties
  // ----
  reset_ctrl_a: assert property (!$past(rst_n_in) || $past(soft_reset_in) |-> ctrl_out == 5'h04)
    else $error("control not at reset value");
  restart_keep_a: assert property (restart_in && !cmd_in.valid && !soft_reset_in |=> $stable(ctrl_out))
    else $error("control changed in restart");
  ctrl_write_a: assert property (wr_ok && cmd_in.addr == wcr_pkg::ADDR_CTRL_A |=>
    ctrl_out.recovery_on == $past(cmd_in.wdata[0]) && ctrl_out.loop_filter_constant == $past(cmd_in.wdata[3:2]))
    else $error("control write not taken");
  clk_write_a: assert property (wr_ok && cmd_in.addr == wcr_pkg::ADDR_CLK_SELECT |=>
    ctrl_out.clk_select == $past(cmd_in.wdata[1:0])) else $error("clock select write not taken");
  reserved_zero_a: assert property (rdata_valid_out |->
    !($past(cmd_in.addr) == wcr_pkg::ADDR_CTRL_A && (rdata_out & 8'hF2) != 8'h00) &&
    !($past(cmd_in.addr) == wcr_pkg::ADDR_CLK_SELECT && rdata_out[7:2] != 6'h00))
    else $error("reserved bit read as one");
  clamp_upper_a: assert property (measure_update_out |-> measured_bit_length_out <= upper_reg)
    else $error("bit time above upper bound");
  clamp_lower_a: assert property (measure_update_out |-> measured_bit_length_out >= lower_reg)
    else $error("bit time below lower bound");
  recovery_off_a: assert property (!ctrl_out.recovery_on |=> !measure_update_out)
    else $error("update while recovery off");
  update_only_a: assert property ($changed(measured_bit_length_out) && $past(rst_n_in) &&
    !$past(soft_reset_in) |-> measure_update_out) else $error("bit time moved without update");
  update_pulse_a: assert property (measure_update_out |=> !measure_update_out)
    else $error("update pulse too long");
endmodule
bind wcr_config_regs wcr_config_regs_sva i_wcr_config_regs_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .soft_reset_in(soft_reset_in), .restart_in(restart_in), .cmd_in(cmd_in), .cal_load_in(cal_load_in),
  .cal_value_in(cal_value_in), .rx_in(rx_in), .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out),
  .ctrl_out(ctrl_out), .measured_bit_length_out(measured_bit_length_out),
  .measure_update_out(measure_update_out));
`default_nettype wire

// >>> dv/wcr_rx_model.sv
// receive-line model: sends falling edges two bit times apart
// assumes go_in is raised for one cycle; line idles recessive high
`timescale 1ns/10ps
`default_nettype none
module wcr_rx_model (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [8:0] bit_cycles_in,
  input  wire logic [4:0] falls_in,
  output var  logic       rx_out,
  output var  logic       busy_out
);
  initial begin
    rx_out = 1'b1;
    busy_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (go_in) begin
        busy_out <= 1'b1;
        for (int f = 0; f < falls_in; f++) begin
          rx_out <= 1'b0;
          repeat (bit_cycles_in) @(posedge clk_in);
          rx_out <= 1'b1;
          repeat (bit_cycles_in) @(posedge clk_in);
        end
        busy_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb_wcr_config_regs.sv
// self-checking bench for the wake recovery register bank
// assumes the receive-line model and the bound checker beside it
`timescale 1ns/10ps
`default_nettype none
module tb_wcr_config_regs;
  logic               clk_in, rst_n_in, soft_reset_in, restart_in, cal_load_in, go;
  logic               rdata_valid_out, upd, rx, busy;
  logic [7:0]         cal_value_in, rdata_out, meas;
  logic [7:0]         mdl [0:127];
  logic [8:0]         bitc;
  logic [4:0]         nf;
  logic [31:0]        r;
  wcr_pkg::wcr_cmd_t  cmd_in;
  wcr_pkg::wcr_ctrl_t ctrl_out;
  int                 n_errors, tests_run, n_upd, seed;

  wcr_config_regs i_wcr_config_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .soft_reset_in(soft_reset_in),
    .restart_in(restart_in), .cmd_in(cmd_in), .cal_load_in(cal_load_in), .cal_value_in(cal_value_in),
    .rx_in(rx), .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out), .ctrl_out(ctrl_out),
    .measured_bit_length_out(meas), .measure_update_out(upd));
  wcr_rx_model i_wcr_rx_model (.clk_in(clk_in), .go_in(go), .bit_cycles_in(bitc), .falls_in(nf),
    .rx_out(rx), .busy_out(busy));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (upd === 1'b1) n_upd <= n_upd + 1;
  // ----
  // expectation and bus tasks
  // ----
  // only writable fields survive; read-only and unmapped places keep old value
  function automatic logic [7:0] stored(logic [6:0] a, logic [7:0] d, logic [7:0] old);
    case (a)
      7'h3C: return d & 8'h0D;
      7'h3D: return d & 8'h03;
      7'h3E, 7'h3F: return d;
      default: return old;
    endcase
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic reset_model();
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[7'h3C] = 8'h04;
    mdl[7'h3E] = 8'hA8;
    mdl[7'h3F] = 8'h98;
  endtask
  task automatic access(logic w, logic [6:0] a, logic [7:0] d);
    @(posedge clk_in);
    cmd_in <= {1'b1, w, a, d};
    @(posedge clk_in);
    cmd_in.valid <= 1'b0;
    #1;
    check({7'h00, rdata_valid_out}, 8'h01);
    check(rdata_out, mdl[a]);
    if (w) mdl[a] = stored(a, d, mdl[a]);
    #1;
    check({3'h0, ctrl_out}, {3'h0, mdl[7'h3C][0], mdl[7'h3C][3:2], mdl[7'h3D][1:0]});
  endtask
  task automatic read_all();
    for (int a = 'h3B; a <= 'h3F; a++) access(1'b0, a[6:0], 8'h00);
  endtask
  task automatic send(logic [8:0] b, logic [4:0] f);
    int n;
    @(posedge clk_in);
    bitc <= b;
    nf <= f;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    #1;
    for (n = 0; busy && n < 20000; n++) begin
      @(posedge clk_in);
      #1;
    end
    if (busy) begin
      n_errors++;
      conclude();
    end
    repeat (4) @(posedge clk_in);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    seed = 32'h4528b5db;
    {rst_n_in, soft_reset_in, restart_in, cal_load_in, go} = 5'h00;
    {cal_value_in, bitc, nf, n_errors, tests_run, n_upd} = '0;
    cmd_in = '0;
    reset_model();
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    read_all();
    $display("test reset done");
    @(posedge clk_in);
    cal_value_in <= 8'h5A;
    cal_load_in <= 1'b1;
    @(posedge clk_in);
    cal_load_in <= 1'b0;
    mdl[7'h3B] = 8'h5A;
    access(1'b1, 7'h3B, 8'hFF);
    access(1'b0, 7'h3B, 8'h00);
    for (int c = 0; c < 4; c++) begin
      access(1'b1, 7'h3C, {4'hF, c[1:0], 2'h2});
      access(1'b1, 7'h3D, {6'h3F, c[1:0]});
    end
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      access(r[8], 7'h3A + 7'(r[2:0] % 3'h7), r[23:16]);
    end
    $display("test access done");
    @(posedge clk_in);
    restart_in <= 1'b1;
    read_all();
    @(posedge clk_in);
    restart_in <= 1'b0;
    @(posedge clk_in);
    soft_reset_in <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    reset_model();
    read_all();
    $display("test restart done");
    access(1'b1, 7'h3D, 8'h01);
    n_upd = 0;
    send(9'd160, 5'd4);
    check(8'(n_upd), 8'h00);
    check(meas, 8'hA0);
    access(1'b1, 7'h3C, 8'h01);
    access(1'b1, 7'h3E, 8'hA4);
    send(9'd170, 5'd12);
    check(meas, 8'hA4);
    check(8'(n_upd), 8'h0B);
    access(1'b1, 7'h3E, 8'hA8);
    access(1'b1, 7'h3F, 8'h9C);
    send(9'd150, 5'd12);
    check(meas, 8'h9C);
    // half-rate recovery clock: the gap still spans two bits and clamps high
    access(1'b1, 7'h3D, 8'h02);
    access(1'b1, 7'h3E, 8'hA4);
    send(9'd340, 5'd12);
    check(meas, 8'hA4);
    // adaptive filter on two-bit gaps must use the slow constant of 32
    access(1'b1, 7'h3D, 8'h01);
    access(1'b1, 7'h3E, 8'hA8);
    access(1'b1, 7'h3C, 8'h0D);
    send(9'd150, 5'd3);
    check(meas, 8'hA3);
    $display("test clamp done");
    conclude();
  end
endmodule
`default_nettype wire
